/* File: src/ido_display_override_stats.sv */
// Front-panel screens, bypass timer and 24-hour sensor statistics
`timescale 1ns/1ps
`default_nettype none
`include "ido_cfg.svh"

// Behaviour
// R1 - First bypass press shows status, no change
// R2 - Four idle seconds return to entry screen
// R3 - Entered from non-sensor screen returns first
// R4 - Further bypass presses toggle shown status
// R5 - Status committed only when leaving screen
// R6 - On-off-on toggle reloads countdown on leave
// R7 - Advance leaves bypass screen, applies change
// R8 - Committed on starts countdown, zero forces off
// R9 - Countdown minutes, 0 to 9999, default 120
// R10 - Rotate only with several screens, fixed order
// R11 - Manual advance steps, wraps to first
// R12 - Manual 30 seconds off temperature returns first
// R13 - Automatic four-second steps, advance steps too
// R14 - Raise, lower, advance held 8 s enter data
// R15 - Data display refreshes temperature every second
// R16 - Humidity and CO2 refresh every two seconds
// R17 - Min, max, average over 24-hour window
// R18 - Statistics volatile, cleared by power-on reset
// R19 - Temperature shown in configured unit
// R20 - Humidity in percent RH, CO2 in ppm
// R21 - Reset enables temperature screen only
// R22 - Window expiry restarts statistics
// R23 - Second and minute ticks from clock
module ido_display_override_stats #(
  parameter int unsigned CPS = `IDO_SEC_US * `IDO_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Keypad pins: raise, lower, bypass, advance
  input  wire logic [3:0]  key_pin,
  // Sensor samples, same clock domain
  input  wire logic        sens_valid,
  input  wire logic [15:0] temp_in,
  input  wire logic [15:0] hum_in,
  input  wire logic [15:0] co2_in,
  // Display state
  output logic [2:0]       disp_screen,
  output logic             byp_shown,
  output logic             byp_active,
  output logic             data_mode
);
  localparam logic [31:0] CPS_M1   = 32'(CPS - 1);
  localparam logic [31:0] HOLD_CYC = 32'(64'(`IDO_HOLD_S) * 64'(CPS));

  ido_pkg::ido_state_t s;
  ido_pkg::ido_state_t next_s;

  // =====================================================================
  // Helpers
  function automatic ido_pkg::ido_state_t rst_val();
    ido_pkg::ido_state_t r;
    r = '0;
    r.en = `IDO_EN_RST;
    r.byp_len = `IDO_BLEN_RST;
    return r;
  endfunction

  localparam ido_pkg::ido_state_t RST_S = rst_val();

  function automatic ido_pkg::ido_scr_t first_en(input logic [3:0] en);
    ido_pkg::ido_scr_t r;
    r = ido_pkg::SCR_TEMP;
    for (int k = 3; k >= 0; k--)
      if (en[k]) r = ido_pkg::ido_scr_t'(3'(k));
    return r;
  endfunction

  // Smallest enabled screen above cur, else wrap to the first
  function automatic ido_pkg::ido_scr_t next_en(input ido_pkg::ido_scr_t cur,
                                                input logic [3:0] en);
    ido_pkg::ido_scr_t r;
    r = first_en(en);
    for (int k = 3; k >= 0; k--)
      if (en[k] && 3'(k) > cur) r = ido_pkg::ido_scr_t'(3'(k));
    return r;
  endfunction

  function automatic logic multi(input logic [3:0] en);
    return (en & (en - 4'h1)) != 4'h0;
  endfunction

  // Temperature is kept in tenths Celsius; converted on the way out
  function automatic logic [15:0] to_unit(input logic [15:0] v, input logic cels);
    logic signed [31:0] t;
    t = $signed(32'($signed(v))) * `IDO_F_MUL / `IDO_F_DIV + `IDO_F_OFS;
    return cels ? v : t[15:0];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a < `IDO_END);
  endfunction

  // =====================================================================
  // Next-state logic
  logic [3:0]          press;
  logic                combo;
  logic                enter;
  logic                sec_tick;
  logic                v_tick;
  logic                is_sens;
  logic                day_end;
  logic                fresh;
  ido_pkg::ido_scr_t   fe;
  logic signed [47:0]  q;
  logic [15:0]         sv [3];
  logic [7:0]          base;

  always_comb
  begin
    next_s = s;
    q = '0;
    base = '0;
    sv[0] = temp_in;
    sv[1] = hum_in;
    sv[2] = co2_in;
    // Pins pass two flops; the edge compares stage two with stage three
    next_s.k1 = key_pin;
    next_s.k2 = s.k1;
    next_s.k3 = s.k2;
    press = s.k2 & ~s.k3;
    combo = s.k2[`IDO_K_RAISE] & s.k2[`IDO_K_LOWER] & s.k2[`IDO_K_ADV];
    fe = first_en(s.en);
    is_sens = s.scr <= ido_pkg::SCR_VOC;

    // Free second tick; minutes derive from it
    sec_tick = s.pre == CPS_M1; // R23
    next_s.pre = sec_tick ? 32'h0 : s.pre + 32'h1;
    if (sec_tick)
      next_s.sec_odd = ~s.sec_odd;

    // View timer restarts on any press or screen change
    v_tick = s.view_cyc == CPS_M1;
    next_s.view_cyc = v_tick ? 32'h0 : s.view_cyc + 32'h1;
    if (v_tick && s.view_sec != `IDO_MAN_S)
      next_s.view_sec = s.view_sec + 5'h1;

    // Three-key hold; fires once per hold
    enter = combo && s.hold_cyc == HOLD_CYC - 32'h1; // R14
    if (!combo)
      next_s.hold_cyc = 32'h0;
    else if (s.hold_cyc != HOLD_CYC)
      next_s.hold_cyc = s.hold_cyc + 32'h1;

    // Bypass countdown, one minute per 60 ticks
    if (s.byp_on)
    begin
      if (s.byp_left == 14'h0)
        next_s.byp_on = 1'b0; // R8
      else if (sec_tick)
      begin
        next_s.byp_sec = (s.byp_sec == `IDO_MIN_S) ? 6'h0 : s.byp_sec + 6'h1;
        if (s.byp_sec == `IDO_MIN_S)
          next_s.byp_left = s.byp_left - 14'h1; // R23
      end
    end

    // Screen sequencing
    if (press[`IDO_K_BYP] && s.scr != ido_pkg::SCR_BYP)
    begin
      next_s.scr = ido_pkg::SCR_BYP;
      next_s.ret = is_sens ? s.scr : fe; // R2 R3
      next_s.byp_show = s.byp_on; // R1
      next_s.saw_off = 1'b0;
      next_s.reload = 1'b0;
    end
    else
    begin
      case (s.scr)
        ido_pkg::SCR_BYP:
        begin
          if (press[`IDO_K_ADV] || (s.view_sec == `IDO_VIEW_S && press == 4'h0))
          begin
            // Commit only here; a fresh period when newly on or on-off-on
            next_s.scr = s.ret; // R2 R7
            next_s.byp_on = s.byp_show; // R5 R7
            if (s.byp_show && (!s.byp_on || s.reload))
            begin
              next_s.byp_left = s.byp_len; // R6 R8 R9
              next_s.byp_sec = 6'h0;
            end
          end
          else if (press[`IDO_K_BYP])
          begin
            next_s.byp_show = ~s.byp_show; // R4
            if (s.byp_show)
              next_s.saw_off = 1'b1;
            else if (s.saw_off)
              next_s.reload = 1'b1; // R6
          end
        end
        ido_pkg::SCR_DATA:
        begin
          // Left only through the bypass key; its timeout lands on fe
          next_s.scr = ido_pkg::SCR_DATA;
        end
        default:
        begin
          if (enter)
            next_s.scr = ido_pkg::SCR_DATA; // R14
          else if (!s.en[s.scr[1:0]])
            next_s.scr = fe;
          else if (press[`IDO_K_ADV] && !combo && multi(s.en))
            next_s.scr = next_en(s.scr, s.en); // R10 R11 R13
          // At or past four seconds, so a timer that ran on in manual mode cannot stall auto
          else if (s.auto && multi(s.en) && s.view_sec >= `IDO_VIEW_S && press == 4'h0)
            next_s.scr = next_en(s.scr, s.en); // R13
          else if (!s.auto && s.scr != ido_pkg::SCR_TEMP && s.scr != fe
                   && s.view_sec == `IDO_MAN_S)
            next_s.scr = fe; // R12
        end
      endcase
    end
    if (next_s.scr != s.scr || press != 4'h0)
    begin
      next_s.view_cyc = 32'h0;
      next_s.view_sec = 5'h0;
    end

    // Data display refresh: entry loads all, then 1 s and 2 s rates
    fresh = next_s.scr == ido_pkg::SCR_DATA && s.scr != ido_pkg::SCR_DATA;
    if (fresh || (s.scr == ido_pkg::SCR_DATA && sec_tick))
      next_s.cur[0] = temp_in; // R15
    if (fresh || (s.scr == ido_pkg::SCR_DATA && sec_tick && s.sec_odd))
    begin
      next_s.cur[1] = hum_in; // R16
      next_s.cur[2] = co2_in; // R16
    end

    // 24-hour window; power-on reset clears all of it
    day_end = sec_tick && s.day_sec == `IDO_DAY_S - 17'h1;
    if (sec_tick)
      next_s.day_sec = day_end ? 17'h0 : s.day_sec + 17'h1;
    if (day_end)
      next_s.cnt = 32'h0; // R22
    if (sens_valid)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (next_s.cnt == 32'h0)
        begin
          next_s.smin[i] = sv[i]; // R17
          next_s.smax[i] = sv[i];
          next_s.sum[i] = 48'($signed(sv[i]));
        end
        else
        begin
          if ($signed(sv[i]) < $signed(s.smin[i]))
            next_s.smin[i] = sv[i]; // R17
          if ($signed(sv[i]) > $signed(s.smax[i]))
            next_s.smax[i] = sv[i]; // R17
          next_s.sum[i] = s.sum[i] + 48'($signed(sv[i]));
        end
      end
      next_s.cnt = next_s.cnt + 32'h1;
    end
    // Averages lag the sums by one cycle
    for (int i = 0; i < 3; i++)
    begin
      q = (s.cnt == 32'h0) ? 48'sh0 : $signed(s.sum[i]) / $signed({16'h0, s.cnt});
      next_s.avg[i] = q[15:0]; // R17
    end

    // APB: decode in setup, write at the access edge
    if (psel && !penable)
    begin
      next_s.pslverr = !mapped(paddr) || (pwrite && paddr >= `IDO_STAT);
      next_s.prdata = 32'h0;
      case (paddr)
        `IDO_CTRL:
          next_s.prdata = {26'h0, s.cels, s.auto, s.en};
        `IDO_BLEN:
          next_s.prdata = {18'h0, s.byp_len};
        `IDO_STAT:
          next_s.prdata = {2'h0, s.byp_left, 11'h0, s.byp_show, s.byp_on, s.scr};
        default:
        begin
          for (int i = 0; i < 3; i++)
          begin
            base = `IDO_SENS0 + 8'(i) * `IDO_STRIDE;
            // Temperature in selected unit; RH and ppm pass as they are
            if (paddr == base)
              next_s.prdata = {16'h0, i == 0 ? to_unit(s.cur[i], s.cels) : s.cur[i]}; // R19 R20
            if (paddr == base + 8'h4)
              next_s.prdata = i == 0 ? {to_unit(s.smax[i], s.cels), to_unit(s.smin[i], s.cels)}
                                     : {s.smax[i], s.smin[i]}; // R19 R20
            if (paddr == base + 8'h8)
              next_s.prdata = {16'h0, i == 0 ? to_unit(s.avg[i], s.cels) : s.avg[i]}; // R19
          end
        end
      endcase
    end
    if (psel && penable && pwrite)
    begin
      case (paddr)
        `IDO_CTRL:
        begin
          next_s.en = pwdata[3:0];
          next_s.auto = pwdata[`IDO_F_AUTO];
          next_s.cels = pwdata[`IDO_F_CELS];
        end
        `IDO_BLEN:
          next_s.byp_len = (pwdata > 32'(`IDO_BLEN_MAX)) ? `IDO_BLEN_MAX : pwdata[13:0]; // R9
        default:
          next_s.byp_len = s.byp_len;
      endcase
    end
  end

  // =====================================================================
  // State register; ce low freezes everything
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= RST_S; // R18 R21 R9
    else if (ce)
      s <= next_s;
  end

  // Outputs
  assign pready      = psel & penable;
  assign prdata      = s.prdata;
  assign pslverr     = s.pslverr & psel & penable;
  assign disp_screen = s.scr;
  assign byp_shown   = s.byp_show;
  assign byp_active  = s.byp_on;
  assign data_mode   = s.scr == ido_pkg::SCR_DATA;

  // =====================================================================
  // Checks
  AST_BYP_ENTRY: assert property (@(posedge clk) disable iff (rst) // R1
    ce && press[`IDO_K_BYP] && s.scr != ido_pkg::SCR_BYP |=>
      s.scr == ido_pkg::SCR_BYP && s.byp_show == $past(s.byp_on))
    else $error("bypass entry shows wrong status");

  AST_BYP_RETURN: assert property (@(posedge clk) disable iff (rst) // R2
    ce && s.scr == ido_pkg::SCR_BYP && s.view_sec == `IDO_VIEW_S && press == 4'h0 |=>
      s.scr == $past(s.ret))
    else $error("bypass timeout did not return");

  AST_BYP_FIRST: assert property (@(posedge clk) disable iff (rst) // R3
    ce && press[`IDO_K_BYP] && s.scr == ido_pkg::SCR_DATA |=> s.ret == $past(fe))
    else $error("bypass return screen not first enabled");

  AST_TOGGLE: assert property (@(posedge clk) disable iff (rst) // R4
    ce && s.scr == ido_pkg::SCR_BYP && press == 4'h4 && s.view_sec != `IDO_VIEW_S |=>
      s.byp_show != $past(s.byp_show))
    else $error("bypass press did not toggle");

  AST_NO_COMMIT: assert property (@(posedge clk) disable iff (rst) // R5
    s.scr == ido_pkg::SCR_BYP && !s.byp_on ##1 s.scr == ido_pkg::SCR_BYP |-> !s.byp_on)
    else $error("bypass committed while screen shown");

  AST_RELOAD: assert property (@(posedge clk) disable iff (rst) // R6
    ce && s.scr == ido_pkg::SCR_BYP && s.reload && s.byp_show && press[`IDO_K_ADV] |=>
      s.byp_on && s.byp_left == $past(s.byp_len))
    else $error("countdown not reloaded");

  AST_ADV_EXIT: assert property (@(posedge clk) disable iff (rst) // R7
    ce && s.scr == ido_pkg::SCR_BYP && press[`IDO_K_ADV] |=>
      s.scr != ido_pkg::SCR_BYP && s.byp_on == $past(s.byp_show))
    else $error("advance did not leave bypass");

  AST_ZERO_OFF: assert property (@(posedge clk) disable iff (rst) // R8
    ce && s.byp_on && s.byp_left == 14'h0 && s.scr != ido_pkg::SCR_BYP |=> !s.byp_on)
    else $error("bypass not forced off at zero");

  AST_LEN_RANGE: assert property (@(posedge clk) disable iff (rst) // R9
    s.byp_len <= `IDO_BLEN_MAX)
    else $error("bypass length out of range");

  AST_SINGLE: assert property (@(posedge clk) disable iff (rst) // R10
    ce && !multi(s.en) && is_sens && s.en[s.scr[1:0]] && !enter && !press[`IDO_K_BYP] |=>
      $stable(s.scr))
    else $error("rotation with one screen");

  AST_WRAP: assert property (@(posedge clk) disable iff (rst) // R11
    ce && is_sens && s.en[s.scr[1:0]] && press == 4'h8 && multi(s.en) && !enter |=>
      s.scr == $past(next_en(s.scr, s.en)))
    else $error("advance did not step to next screen");

  AST_DATA_HOLD: assert property (@(posedge clk) disable iff (rst) // R14
    s.scr != ido_pkg::SCR_DATA ##1 s.scr == ido_pkg::SCR_DATA |->
      $past(s.hold_cyc) == HOLD_CYC - 32'h1)
    else $error("data display without full hold");

  AST_MINMAX: assert property (@(posedge clk) disable iff (rst) // R17
    s.cnt != 32'h0 |-> $signed(s.smin[0]) <= $signed(s.smax[0]))
    else $error("temperature minimum above maximum");
endmodule
`default_nettype wire

/* File: src/ido_cfg.svh */
// Constants for the display, bypass and statistics front-panel block
`ifndef IDO_CFG_SVH
`define IDO_CFG_SVH
// Clock and time base
`define IDO_CLK_MHZ   250
`define IDO_SEC_US    1000000
`define IDO_VIEW_S    5'h4
`define IDO_MAN_S     5'h1e
`define IDO_HOLD_S    8
`define IDO_MIN_S     6'h3b
`define IDO_DAY_S     17'h15180
// Key positions
`define IDO_K_RAISE   0
`define IDO_K_LOWER   1
`define IDO_K_BYP     2
`define IDO_K_ADV     3
// Reset values and limits
`define IDO_EN_RST    4'h1
`define IDO_BLEN_RST  14'h78
`define IDO_BLEN_MAX  14'h270f
// Register byte offsets
`define IDO_CTRL      8'h00
`define IDO_BLEN      8'h04
`define IDO_STAT      8'h08
`define IDO_SENS0     8'h0c
`define IDO_STRIDE    8'h0c
`define IDO_END       8'h30
// Field positions
`define IDO_F_AUTO    4
`define IDO_F_CELS    5
`define IDO_F_BON     3
`define IDO_F_BSHOW   4
`define IDO_F_LEFT    16
// Fahrenheit conversion on tenths of a degree
`define IDO_F_MUL     32'sh9
`define IDO_F_DIV     32'sh5
`define IDO_F_OFS     32'sh140
`endif

/* File: src/ido_pkg.sv */
// Types for the display, bypass and statistics front-panel block
package ido_pkg;
  typedef enum logic [2:0] {SCR_TEMP, SCR_HUM, SCR_CO2, SCR_VOC, SCR_BYP, SCR_DATA} ido_scr_t;

  typedef struct packed {
    logic [3:0]        k1;
    logic [3:0]        k2;
    logic [3:0]        k3;
    ido_scr_t          scr;
    ido_scr_t          ret;
    logic [3:0]        en;
    logic              auto;
    logic              cels;
    logic [13:0]       byp_len;
    logic              byp_on;
    logic              byp_show;
    logic              saw_off;
    logic              reload;
    logic [13:0]       byp_left;
    logic [5:0]        byp_sec;
    logic [31:0]       pre;
    logic [31:0]       view_cyc;
    logic [4:0]        view_sec;
    logic [31:0]       hold_cyc;
    logic [16:0]       day_sec;
    logic              sec_odd;
    logic [2:0][15:0]  cur;
    logic [2:0][15:0]  smin;
    logic [2:0][15:0]  smax;
    logic [2:0][15:0]  avg;
    logic [2:0][47:0]  sum;
    logic [31:0]       cnt;
    logic [31:0]       prdata;
    logic              pslverr;
  } ido_state_t;
endpackage

/* File: dv/ido_keypad.sv */
// Keypad partner model: raw key levels for the front-panel block
`timescale 1ns/1ps
`default_nettype none
// ====================
// Key model
module ido_keypad (
  // Clock
  input  wire logic       clk,
  // Raw key levels, high while pressed
  output logic      [3:0] key_pin
);
  // Released keys read low, as with a pull-down
  initial key_pin = 4'h0;

  // One tap: long enough for the sync chain, then an idle gap
  task automatic tap(input int k);
    @(posedge clk);
    key_pin[k] <= 1'b1;
    repeat (4) @(posedge clk);
    key_pin[k] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Chord held n cycles, all keys let go together
  task automatic chord(input logic [3:0] m, input int n);
    @(posedge clk);
    key_pin <= m;
    repeat (n) @(posedge clk);
    key_pin <= 4'h0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: dv/ido_display_override_stats_tb.sv */
// Self-checking bench for the screens, bypass timer and statistics
`timescale 1ns/1ps
`default_nettype none
`include "ido_cfg.svh"
// ====================
// Bench top
module ido_display_override_stats_tb;
  localparam int unsigned CPS = 20;
  logic        clk, rst, psel, penable, pwrite, sens_valid, pready, pslverr, er;
  logic        byp_shown, byp_active, data_mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] temp_in, hum_in, co2_in;
  logic [3:0]  key_pin;
  logic [2:0]  disp_screen;
  int          err_count, total_checks, n;

  // Short second keeps the view, hold and one-minute bypass timers within a brief run
  ido_display_override_stats #(.CPS(CPS)) dut (
    .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .key_pin(key_pin),
    .sens_valid(sens_valid), .temp_in(temp_in), .hum_in(hum_in), .co2_in(co2_in),
    .disp_screen(disp_screen), .byp_shown(byp_shown), .byp_active(byp_active),
    .data_mode(data_mode));
  ido_keypad kp (.clk(clk), .key_pin(key_pin));

  // ====================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Request held until pready is seen; data and error taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd, exp);
  endtask

  task automatic scr_is(input logic [2:0] v);
    check("screen", 32'(disp_screen), 32'(v));
  endtask

  // Bounded wait for a screen, then compare
  task automatic wait_scr(input logic [2:0] v, input int lim);
    n = 0;
    while (disp_screen !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    scr_is(v);
  endtask

  task automatic sample(input logic [15:0] t, input logic [15:0] h, input logic [15:0] c);
    @(posedge clk);
    sens_valid <= 1'b1;
    temp_in    <= t;
    hum_in     <= h;
    co2_in     <= c;
    @(posedge clk);
    sens_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ====================
  // Scenarios
  task automatic t_reset();
    rdchk(`IDO_CTRL, {28'h0, `IDO_EN_RST});
    rdchk(`IDO_BLEN, 32'h78);
    apb(1'b1, `IDO_BLEN, 32'h3000);
    rdchk(`IDO_BLEN, {18'h0, `IDO_BLEN_MAX});
    apb(1'b1, `IDO_BLEN, 32'h1);
    apb(1'b0, `IDO_END, 32'h0);
    check("pslverr", 32'(er), 32'h1);
  endtask

  task automatic t_bypass();
    kp.tap(`IDO_K_BYP);
    scr_is(3'h4);
    check("shown", 32'(byp_shown), 32'h0);
    kp.tap(`IDO_K_BYP);
    check("shown", 32'(byp_shown), 32'h1);
    check("active", 32'(byp_active), 32'h0);
    repeat (62) @(posedge clk);
    scr_is(3'h4);
    wait_scr(3'h0, 40);
    check("active", 32'(byp_active), 32'h1);
    // One-minute length: off between 59 and 60 seconds after commit
    n = 0;
    while (byp_active === 1'b1 && n < 1400)
    begin
      @(posedge clk);
      n++;
    end
    check("countdown", 32'(n >= 59 * CPS - 3 && n <= 60 * CPS + 3), 32'h1);
  endtask

  task automatic t_rotate();
    apb(1'b1, `IDO_CTRL, 32'hf);
    for (int i = 1; i <= 4; i++)
    begin
      kp.tap(`IDO_K_ADV);
      scr_is(3'(i % 4));
    end
    apb(1'b1, `IDO_CTRL, 32'h1);
    kp.tap(`IDO_K_ADV);
    scr_is(3'h0);
    apb(1'b1, `IDO_CTRL, 32'h5);
    kp.tap(`IDO_K_ADV);
    scr_is(3'h2);
    repeat (555) @(posedge clk);
    scr_is(3'h2);
    wait_scr(3'h0, 80);
    repeat (100) @(posedge clk);
    scr_is(3'h0);
  endtask

  task automatic t_exit();
    kp.tap(`IDO_K_BYP);
    kp.tap(`IDO_K_BYP);
    kp.tap(`IDO_K_ADV);
    check("left", 32'(disp_screen != 3'h4), 32'h1);
    check("active", 32'(byp_active), 32'h1);
    // On, off, on again within one visit, then advance
    kp.tap(`IDO_K_BYP);
    kp.tap(`IDO_K_BYP);
    kp.tap(`IDO_K_BYP);
    check("shown", 32'(byp_shown), 32'h1);
    kp.tap(`IDO_K_ADV);
    check("active", 32'(byp_active), 32'h1);
    kp.tap(`IDO_K_BYP);
    kp.tap(`IDO_K_BYP);
    kp.tap(`IDO_K_ADV);
    check("active", 32'(byp_active), 32'h0);
  endtask

  task automatic t_auto();
    apb(1'b1, `IDO_CTRL, 32'h13);
    wait_scr(3'h1, 200);
    n = 0;
    while (disp_screen === 3'h1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    // Four seconds of view, plus the edge that registers the switch
    check("dwell", 32'(n), 32'(4 * CPS + 1));
    scr_is(3'h0);
  endtask

  task automatic t_data();
    apb(1'b1, `IDO_CTRL, 32'h22);
    sample(16'd100, 16'd4000, 16'd800);
    sample(16'd300, 16'd6000, 16'd1200);
    // Raise, lower and advance together (bits 0, 1, 3)
    fork
      kp.chord(4'hb, 8 * CPS + 20);
      begin
        repeat (8 * CPS - 20) @(posedge clk);
        check("data", 32'(data_mode), 32'h0);
        repeat (45) @(posedge clk);
        check("data", 32'(data_mode), 32'h1);
      end
    join
    rdchk(`IDO_SENS0, 32'h12c);
    rdchk(8'h10, 32'h012c0064);
    rdchk(8'h14, 32'hc8);
    rdchk(8'h1c, 32'h17700fa0);
    rdchk(8'h20, 32'h1388);
    rdchk(8'h28, 32'h04b00320);
    rdchk(8'h2c, 32'h3e8);
    apb(1'b1, `IDO_CTRL, 32'h02);
    rdchk(8'h10, 32'h035c01f4);
    rdchk(8'h14, 32'h2a8);
    sample(16'd200, 16'd5000, 16'd1000);
    repeat (CPS + 2) @(posedge clk);
    rdchk(`IDO_SENS0, 32'h2a8);
    repeat (CPS) @(posedge clk);
    rdchk(8'h18, 32'h1388);
    kp.tap(`IDO_K_BYP);
    scr_is(3'h4);
    wait_scr(3'h1, 120);
  endtask

  // Second power-on reset must wipe the statistics
  task automatic t_power();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    sample(16'd50, 16'd10, 16'd20);
    rdchk(8'h10, 32'h019a019a);
    rdchk(8'h1c, 32'h000a000a);
  endtask

  // ====================
  // Clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    sens_valid = 1'b0;
    temp_in = 16'h0;
    hum_in = 16'h0;
    co2_in = 16'h0;
    err_count = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_bypass();
    t_rotate();
    t_exit();
    t_auto();
    t_data();
    t_power();
    conclude();
  end
endmodule
`default_nettype wire
